// file: bench/terminal_serial_transmitter_bench.sv
// self-checking bench for the terminal serial transmitter
`timescale 1ns/10ps
`default_nettype none

module terminal_serial_transmitter_bench;
  import tst_pkg::*;
  logic sys_clk, reset_n, global_clear, dot_divided_clock, split_rate_enable, clear_to_send;
  logic tx_load_n, stop_two_sel, eight_bit_sel, parity_even_sel, parity_off, eighth_bit_level;
  logic break_key, ext_port_data, line_driver_select;
  logic [3:0] rx_rate_sel, tx_rate_sel, nb;
  logic [6:0] tx_char_bits;
  logic holding_empty_flag, shifter_empty_flag, request_to_send, serial_data;
  logic eia_txd, loop_txd, rx_bit_clock, tx_bit_clock;
  logic [11:0] word, w;
  logic [11:0] cfg [6];
  logic [7:0] d8;
  logic [15:0] n;
  int num_errors, cmp_count, k, r, nd;

  tst_transmitter i_tst_transmitter (.sys_clk, .reset_n, .global_clear, .dot_divided_clock,
    .rx_rate_sel, .split_rate_enable, .tx_rate_sel, .clear_to_send, .tx_load_n, .tx_char_bits,
    .stop_two_sel, .eight_bit_sel, .parity_even_sel, .parity_off, .eighth_bit_level, .break_key,
    .ext_port_data, .line_driver_select, .holding_empty_flag, .shifter_empty_flag,
    .request_to_send, .serial_data, .eia_txd, .loop_txd, .rx_bit_clock, .tx_bit_clock);

  tst_line_monitor i_tst_line_monitor (.sys_clk, .line(eia_txd), .nbits(nb), .word);

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // fast dot clock, four system clocks a period, keeps frames short
  initial
  begin
    dot_divided_clock = 1'b0;
    forever
    begin
      repeat (2) @(posedge sys_clk);
      #1;
      dot_divided_clock = ~dot_divided_clock;
    end
  end

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step

  task automatic tick;
    step();
    n++;
  endtask : tick

  task automatic bail;
    num_errors++;
    end_of_test();
  endtask : bail

  task automatic wse(input logic v, input logic [15:0] lim);
    n = 0;
    while (shifter_empty_flag !== v && n < lim)
      tick();
    if (shifter_empty_flag !== v)
      bail();
  endtask : wse

  // period of a bit clock in system clocks, after two settling periods
  task automatic meas(input logic sel, input logic [15:0] exp);
    for (k = 0; k < 3; k++)
    begin
      n = 0;
      while ((sel ? tx_bit_clock : rx_bit_clock) !== 1'b0 && n < 16'd20000)
        tick();
      while ((sel ? tx_bit_clock : rx_bit_clock) !== 1'b1 && n < 16'd20000)
        tick();
    end
    if (n >= 16'd20000)
      bail();
    chk(n, exp);
  endtask : meas

  // source pulses the strobe low for one clock only
  task automatic load(input logic [6:0] c);
    tx_char_bits = c;
    tx_load_n = 1'b0;
    step();
    chk(holding_empty_flag, 1'b0);
    tx_load_n = 1'b1;
    step();
    chk(request_to_send, 1'b1);
  endtask : load

  initial
  begin
    reset_n = 1'b0;
    {global_clear, split_rate_enable, clear_to_send, stop_two_sel, eight_bit_sel} = '0;
    {parity_even_sel, parity_off, eighth_bit_level, break_key} = '0;
    {tx_load_n, ext_port_data, line_driver_select} = 3'h7;
    {rx_rate_sel, tx_rate_sel, nb} = '0;
    tx_char_bits = 7'h00;
    cfg = '{12'h824, 12'h830, 12'hAAD, 12'h558, 12'hFE3, 12'h01F};
    num_errors = 0;
    cmp_count = 0;
    repeat (12) step();
    reset_n = 1'b1;
    step();
    chk({holding_empty_flag, shifter_empty_flag, request_to_send, serial_data, eia_txd,
      loop_txd, tx_bit_clock, rx_bit_clock}, 8'hDE);
    $display("test reset end");
    for (r = 0; r < 6; r++)
    begin
      rx_rate_sel = r[3:0];
      meas(1'b0, 16'd40 << r);
    end
    rx_rate_sel = RATE_1800;
    meas(1'b0, 16'd432);
    rx_rate_sel = RATE_110;
    meas(1'b0, 16'd7040);
    clear_to_send = 1'b1;
    rx_rate_sel = RATE_2400;
    meas(1'b1, 16'd320);
    split_rate_enable = 1'b1;
    rx_rate_sel = RATE_19200;
    tx_rate_sel = RATE_9600;
    meas(1'b1, 16'd80);
    rx_rate_sel = RATE_1800;
    meas(1'b1, 16'd432);
    rx_rate_sel = RATE_19200;
    tx_rate_sel = RATE_1800;
    meas(1'b1, 16'd40);
    split_rate_enable = 1'b0;
    $display("test rates end");
    for (r = 0; r < 6; r++)
    begin
      {stop_two_sel, eight_bit_sel, parity_even_sel, parity_off, eighth_bit_level} = cfg[r][4:0];
      d8 = {eighth_bit_level & eight_bit_sel, cfg[r][11:5]};
      nd = eight_bit_sel ? 8 : 7;
      w = '1;
      w[0] = 1'b0;
      w[8:1] = d8;
      w[nd + 1] = parity_off ? 1'b1 : (parity_even_sel ? ^d8 : ~^d8);
      nb = 4'(nd + 2 - int'(parity_off));
      load(cfg[r][11:5]);
      wse(1'b0, 16'd200);
      chk(holding_empty_flag, 1'b1);
      wse(1'b1, 16'd9000);
      chk((n + 16'd320) / 16'd640, 16'(nb) + 16'(stop_two_sel) + 16'd1);
      chk(word, w);
      step();
      step();
      chk(request_to_send, 1'b0);
    end
    $display("test frames end");
    clear_to_send = 1'b0;
    load(7'h33);
    repeat (300) step();
    chk({holding_empty_flag, shifter_empty_flag, tx_bit_clock}, 3'h3);
    clear_to_send = 1'b1;
    wse(1'b0, 16'd200);
    repeat (300) step();
    // drop clear-to-send inside the start bit: the line must not move on
    clear_to_send = 1'b0;
    repeat (700) step();
    chk({shifter_empty_flag, serial_data, tx_bit_clock}, 3'h1);
    clear_to_send = 1'b1;
    repeat (200) step();
    global_clear = 1'b1;
    step();
    global_clear = 1'b0;
    chk({holding_empty_flag, shifter_empty_flag, serial_data}, 3'h7);
    step();
    step();
    chk(request_to_send, 1'b0);
    $display("test hold and clear end");
    break_key = 1'b1;
    repeat (3) step();
    chk({eia_txd, loop_txd}, 2'h1);
    line_driver_select = 1'b0;
    repeat (3) step();
    chk({eia_txd, loop_txd}, 2'h2);
    break_key = 1'b0;
    ext_port_data = 1'b0;
    repeat (3) step();
    chk({eia_txd, loop_txd}, 2'h2);
    ext_port_data = 1'b1;
    repeat (3) step();
    chk({eia_txd, loop_txd}, 2'h3);
    $display("test line end");
    end_of_test();
  end
endmodule : terminal_serial_transmitter_bench
`default_nettype wire

// file: bench/tst_line_monitor.sv
// remote receiver model that decodes frames from the line
`timescale 1ns/10ps
`default_nettype none

module tst_line_monitor (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic [3:0] nbits,
  output logic [11:0] word
);
  int i;

  // one bit is 640 clocks at the top rate with the fast dot clock
  initial
  begin
    word = '1;
    forever
    begin
      @(posedge sys_clk);
      if (line === 1'b0)
      begin
        repeat (320) @(posedge sys_clk);
        word = '1;
        word[0] = line;
        for (i = 1; i <= nbits; i++)
        begin
          repeat (640) @(posedge sys_clk);
          word[i] = line;
        end
      end
    end
  end
endmodule : tst_line_monitor
`default_nettype wire

// file: core/tst_pkg.sv
// constants, types and reset values for the terminal serial transmitter
package tst_pkg;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned RATE_W = 4;
  localparam int unsigned CHAR_W = 7;
  localparam int unsigned FRAME_W = 12;
  localparam real DOT_CLOCK_MHZ = 3.1104;
  // terminal counts of the three divider stages
  localparam logic [2:0] C1_TC_STD = 3'h4;
  localparam logic [2:0] C1_TC_1800 = 3'h5;
  localparam logic [3:0] C2_TC_STD = 4'hF;
  localparam logic [3:0] C2_TC_1800 = 4'h8;
  localparam logic [3:0] C3_TC_STD = 4'hF;
  localparam logic [3:0] C3_TC_110 = 4'hA;
  // rate select codes, then the last 16x sub-tick and the base frame length
  localparam logic [3:0] RATE_19200 = 4'h0;
  localparam logic [3:0] RATE_9600 = 4'h1;
  localparam logic [3:0] RATE_4800 = 4'h2;
  localparam logic [3:0] RATE_2400 = 4'h3;
  localparam logic [3:0] RATE_1200 = 4'h4;
  localparam logic [3:0] RATE_600 = 4'h5;
  localparam logic [3:0] RATE_300 = 4'h6;
  localparam logic [3:0] RATE_150 = 4'h7;
  localparam logic [3:0] RATE_75 = 4'h8;
  localparam logic [3:0] RATE_1800 = 4'h9;
  localparam logic [3:0] RATE_110 = 4'hA;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] LEN_BASE = 4'h9;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tst_tx_e;

  typedef struct packed {
    logic dot_prev;
    logic [2:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    logic rx_flop;
    logic tx_flop;
    logic rx_clk;
    logic tx_clk;
    logic load_prev;
    logic [CHAR_W-1:0] hold;
    logic holding_empty;
    logic shifter_empty;
    tst_tx_e st;
    logic [FRAME_W-1:0] frame;
    logic [3:0] bits_left;
    logic [3:0] sub;
    logic ser;
    logic rts;
    logic eia;
    logic loop;
  } tst_state_s;

  localparam tst_state_s ST_RESET = '{
    dot_prev: 1'b0, c1: 3'h0, c2: 4'h0, c3: 4'h0,
    rx_flop: 1'b0, tx_flop: 1'b0, rx_clk: 1'b0, tx_clk: 1'b1,
    load_prev: 1'b1, hold: 7'h00, holding_empty: 1'b1,
    shifter_empty: 1'b1, st: TX_IDLE, frame: 12'hFFF,
    bits_left: 4'h0, sub: 4'h0, ser: 1'b1, rts: 1'b0,
    eia: 1'b1, loop: 1'b1
  };
endpackage : tst_pkg

// file: core/tst_transmitter.sv
// serial transmitter with baud divider chain for a display terminal
// Operation
// - both clocks run at sixteen times their bit rate
// - without clear-to-send the transmit clock stays high, nothing shifts
// - load copies the character to the holding buffer, holding-empty falls
// - with clocks and an empty shifter the held character moves in
// - request-to-send is high while either empty flag is low
// - idle high, start low, data lsb first, parity, one or two stops
// - break forces the combined line to spacing
// - extension data, serial output and break merge into one line
// - line select feeds one driver, the other holds marking
// - global clear resets the transmit and receive logic
// - stop select low gives one stop bit, high gives two
// - size select high gives eight data bits, low gives seven
// - parity sense high gives even, low gives odd parity
// - parity-off high suppresses parity and ignores the sense input
// - in eight-bit mode the eighth-bit level sets the eighth bit
// - the dot clock is divided by five, sixteen and sixteen
// - at the top rate the divide-by-five output is halved
// - lower rates take a tap further down the two counters
// - 1800 baud divides by six and nine, tap at the second counter
// - 110 baud divides by five, sixteen and eleven
// - without split rates transmit uses the receive selection
// - no split rates at 110 or 1800, transmit selector lacks 1800
`timescale 1ns/10ps
`default_nettype none

module tst_transmitter (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic global_clear,
  input wire logic dot_divided_clock,
  input wire logic [tst_pkg::RATE_W-1:0] rx_rate_sel,
  input wire logic split_rate_enable,
  input wire logic [tst_pkg::RATE_W-1:0] tx_rate_sel,
  input wire logic clear_to_send,
  input wire logic tx_load_n,
  input wire logic [tst_pkg::CHAR_W-1:0] tx_char_bits,
  input wire logic stop_two_sel,
  input wire logic eight_bit_sel,
  input wire logic parity_even_sel,
  input wire logic parity_off,
  input wire logic eighth_bit_level,
  input wire logic break_key,
  input wire logic ext_port_data,
  input wire logic line_driver_select,
  output logic holding_empty_flag,
  output logic shifter_empty_flag,
  output logic request_to_send,
  output logic serial_data,
  output logic eia_txd,
  output logic loop_txd,
  output logic rx_bit_clock,
  output logic tx_bit_clock
);
  import tst_pkg::*;

  tst_state_s s_r;
  tst_state_s s_nxt;

  // pulse when the selected divider stage completes a cycle
  function automatic logic tap_pulse(
    input logic [3:0] code,
    input logic c1w,
    input logic [3:0] c2,
    input logic c2w,
    input logic [3:0] c3,
    input logic c3w
  );
    logic p;
    p = 1'b0;
    case (code)
      RATE_19200: p = c1w;
      RATE_9600: p = c1w & c2[0];
      RATE_4800: p = c1w & (&c2[1:0]);
      RATE_2400: p = c1w & (&c2[2:0]);
      RATE_1200: p = c2w;
      RATE_600: p = c2w & c3[0];
      RATE_300: p = c2w & (&c3[1:0]);
      RATE_150: p = c2w & (&c3[2:0]);
      RATE_75: p = c3w;
      RATE_1800: p = c2w;
      RATE_110: p = c3w;
      default: p = 1'b0;
    endcase
    return p;
  endfunction : tap_pulse

  logic dot_tick;
  logic [2:0] tc1;
  logic [3:0] tc2;
  logic [3:0] tc3;
  logic c1w;
  logic c2w;
  logic c3w;
  logic split_ok;
  logic rx_dbl;
  logic tx_dbl;
  logic tx16;
  logic load_fall;
  logic [7:0] data8;
  logic par;
  logic [10:0] tail;
  logic [3:0] len;
  logic line;

  always_comb
  begin
    s_nxt = s_r;
    dot_tick = dot_divided_clock & ~s_r.dot_prev;
    s_nxt.dot_prev = dot_divided_clock;
    // divider ratios follow the receive selection
    tc1 = (rx_rate_sel == RATE_1800) ? C1_TC_1800 : C1_TC_STD;
    tc2 = (rx_rate_sel == RATE_1800) ? C2_TC_1800 : C2_TC_STD;
    tc3 = (rx_rate_sel == RATE_110) ? C3_TC_110 : C3_TC_STD;
    c1w = dot_tick & (s_r.c1 == tc1);
    c2w = c1w & (s_r.c2 == tc2);
    c3w = c2w & (s_r.c3 == tc3);
    if (dot_tick)
    begin
      s_nxt.c1 = c1w ? 3'h0 : s_r.c1 + 3'h1;
    end
    if (c1w)
    begin
      s_nxt.c2 = c2w ? 4'h0 : s_r.c2 + 4'h1;
    end
    if (c2w)
    begin
      s_nxt.c3 = c3w ? 4'h0 : s_r.c3 + 4'h1;
    end
    // receive twice-rate clock from the selected tap
    rx_dbl = tap_pulse(rx_rate_sel, c1w, s_r.c2, c2w, s_r.c3, c3w);
    split_ok = split_rate_enable & (rx_rate_sel != RATE_1800) &
      (rx_rate_sel != RATE_110) & (tx_rate_sel != RATE_1800);
    tx_dbl = split_ok ? tap_pulse(tx_rate_sel, c1w, s_r.c2, c2w, s_r.c3, c3w)
      : rx_dbl;
    if (rx_dbl)
    begin
      s_nxt.rx_flop = ~s_r.rx_flop;
    end
    if (tx_dbl)
    begin
      s_nxt.tx_flop = ~s_r.tx_flop;
    end
    s_nxt.rx_clk = s_nxt.rx_flop;
    s_nxt.tx_clk = clear_to_send ? s_nxt.tx_flop : 1'b1;
    // one transmit 16x tick per rising edge, gated by clear-to-send
    tx16 = tx_dbl & ~s_r.tx_flop & clear_to_send;

    // frame assembly from the held character
    data8 = eight_bit_sel ? {eighth_bit_level, s_r.hold}
      : {1'b0, s_r.hold};
    par = parity_even_sel ? ^data8 : ~(^data8);
    if (eight_bit_sel)
    begin
      tail = parity_off ? {3'h7, data8} : {2'h3, par, data8};
    end
    else
    begin
      tail = parity_off ? {4'hF, data8[6:0]} : {3'h7, par, data8[6:0]};
    end
    len = LEN_BASE + {3'h0, eight_bit_sel} + {3'h0, ~parity_off} +
      {3'h0, stop_two_sel};

    unique case (s_r.st)
      TX_IDLE:
      begin
        s_nxt.ser = 1'b1;
        if (tx16 && !s_r.holding_empty)
        begin
          s_nxt.frame = {tail, 1'b0};
          s_nxt.ser = 1'b0;
          s_nxt.bits_left = len - 4'h1;
          s_nxt.sub = 4'h0;
          s_nxt.holding_empty = 1'b1;
          s_nxt.shifter_empty = 1'b0;
          s_nxt.st = TX_SHIFT;
        end
      end
      TX_SHIFT:
      begin
        if (tx16)
        begin
          s_nxt.sub = s_r.sub + 4'h1;
          if (s_r.sub == SUB_LAST)
          begin
            if (s_r.bits_left == 4'h0)
            begin
              s_nxt.ser = 1'b1;
              s_nxt.shifter_empty = 1'b1;
              s_nxt.frame = '1;
              s_nxt.st = TX_IDLE;
            end
            else
            begin
              s_nxt.frame = {1'b1, s_r.frame[FRAME_W-1:1]};
              s_nxt.ser = s_r.frame[1];
              s_nxt.bits_left = s_r.bits_left - 4'h1;
            end
          end
        end
      end
    endcase

    // strobe falling edge takes the character into the holding buffer
    load_fall = s_r.load_prev & ~tx_load_n;
    s_nxt.load_prev = tx_load_n;
    if (load_fall)
    begin
      s_nxt.hold = tx_char_bits;
      s_nxt.holding_empty = 1'b0;
    end
    s_nxt.rts = ~(s_nxt.holding_empty & s_nxt.shifter_empty);

    // merged line and driver selection
    line = s_r.ser & ext_port_data & ~break_key;
    s_nxt.eia = line_driver_select ? line : 1'b1;
    s_nxt.loop = line_driver_select ? 1'b1 : line;

    if (global_clear)
    begin
      s_nxt = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r <= ST_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign holding_empty_flag = s_r.holding_empty;
  assign shifter_empty_flag = s_r.shifter_empty;
  assign request_to_send = s_r.rts;
  assign serial_data = s_r.ser;
  assign eia_txd = s_r.eia;
  assign loop_txd = s_r.loop;
  assign rx_bit_clock = s_r.rx_clk;
  assign tx_bit_clock = s_r.tx_clk;

  // checks
  a_rts_span: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    request_to_send == !(holding_empty_flag && shifter_empty_flag))
    else $error("request to send does not span the character");

  a_cts_clock_high: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !clear_to_send |=> tx_bit_clock)
    else $error("transmit clock not held high without clear to send");

  a_cts_no_shift: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!clear_to_send && !global_clear && !shifter_empty_flag)
      |=> $stable(s_r.sub) && $stable(s_r.frame))
    else $error("shifter moved without clear to send");

  a_load_holds: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ($fell(tx_load_n) && !global_clear) |=>
      !holding_empty_flag && s_r.hold == $past(tx_char_bits))
    else $error("load strobe did not fill the holding buffer");

  a_start_low: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(shifter_empty_flag) |-> !serial_data && $rose(holding_empty_flag))
    else $error("character did not begin with a low start bit");

  a_idle_mark: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    shifter_empty_flag |-> serial_data)
    else $error("serial line not marking while idle");

  a_break_space: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (break_key && line_driver_select && !global_clear) |=> !eia_txd)
    else $error("break did not force spacing");

  a_unsel_mark: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!line_driver_select |=> eia_txd) and (line_driver_select |=> loop_txd))
    else $error("unselected driver not marking");

  a_clear_empty: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    global_clear |=> holding_empty_flag && shifter_empty_flag && !request_to_send)
    else $error("global clear did not empty the transmitter");

  a_top_rate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (rx_rate_sel == RATE_19200 && c1w && !global_clear)
      |=> rx_bit_clock != $past(rx_bit_clock))
    else $error("top rate clock did not follow the divide-by-five tap");

  a_hold_move: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_r.st == TX_IDLE && tx16 && !s_r.holding_empty && !global_clear)
      |=> !shifter_empty_flag && !s_r.frame[0])
    else $error("held character did not move into the shifter");

  a_parity_sense: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_r.st == TX_IDLE && tx16 && !s_r.holding_empty && !global_clear && !parity_off)
      |=> ($past(eight_bit_sel) ? ^s_r.frame[9:1] : ^s_r.frame[8:1]) != $past(parity_even_sel))
    else $error("parity bit does not match the selected sense");

  a_eighth_bit: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_r.st == TX_IDLE && tx16 && !s_r.holding_empty && !global_clear && eight_bit_sel)
      |=> s_r.frame[8] == $past(eighth_bit_level))
    else $error("eighth data bit does not follow its level input");

  a_div_wrap: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (c2w && !global_clear) |=> s_r.c1 == 3'h0 && s_r.c2 == 4'h0)
    else $error("divider stages did not wrap together");

  a_rx_clk_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!rx_dbl && !global_clear) |=> $stable(rx_bit_clock))
    else $error("receive clock moved without a tap pulse");

  a_tx_follows: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!split_rate_enable && rx_dbl && !global_clear) |=> s_r.tx_flop != $past(s_r.tx_flop))
    else $error("transmit clock flop did not follow the receive selection");

  a_split_barred: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (rx_rate_sel == RATE_1800 || rx_rate_sel == RATE_110) |-> tx_dbl == rx_dbl)
    else $error("split rate used at a barred receive rate");

  a_break_loop: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (break_key && !line_driver_select && !global_clear) |=> !loop_txd)
    else $error("break did not force spacing on the loop driver");
endmodule : tst_transmitter

`default_nettype wire
